// *** host_bfm.sv ***
`timescale 1ns/1ps
`default_nettype none
module host_bfm import tuner_pm_pkg::*; (
  // Clock and shutdown pin seen by the host
  input wire logic clk,
  input wire logic hw_off_n_pin,
  // Write port into the block
  output var logic cfg_wr,
  output var cfg_t cfg_wdata
);
  initial {cfg_wr, cfg_wdata} = '0;
  task automatic write(cfg_t v);
    @(posedge clk) {cfg_wr, cfg_wdata} <= {hw_off_n_pin, v};
    // Inverted idle word, so stale data never looks valid
    @(posedge clk) {cfg_wr, cfg_wdata} <= {1'b0, ~v};
    repeat (9) @(negedge clk);
  endtask : write
endmodule : host_bfm
`default_nettype wire

// *** pm_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module pm_props import tuner_pm_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Watched ports
  input wire logic hw_off_n_pin,
  input wire logic wr_accepted,
  input wire cfg_t cfg_rdata,
  input wire pm_mode_t mode,
  input wire dom_en_t dom_en,
  input wire logic lo_to_test,
  input wire logic det_volt_mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  AST_OFF: assert property (mode == MODE_SHUTDOWN |-> dom_en == 5'h00)
    else $error("domain on in shutdown");
  AST_REFUSE: assert property (mode == MODE_SHUTDOWN |-> !wr_accepted)
    else $error("write taken in shutdown");
  AST_PIN: assert property ((!hw_off_n_pin &&
    !cfg_rdata.detector_enable)[*6] |-> mode == MODE_SHUTDOWN)
    else $error("pin low ignored");
  AST_PD: assert property (mode == MODE_POWERDOWN |-> dom_en[4:2] == 3'h2)
    else $error("power-down domains");
  AST_SB: assert property (mode == MODE_STANDBY |-> dom_en[4:2] == 3'h3)
    else $error("standby domains");
  AST_HOLD: assert property (!wr_accepted |=> $stable(cfg_rdata))
    else $error("config changed");
  AST_LO: assert property (lo_to_test |-> cfg_rdata.diag_sel == 3'h7)
    else $error("lo route wrong");
  AST_DET: assert property (det_volt_mode |-> cfg_rdata.diag_sel == 3'h4)
    else $error("detector mode wrong");
  COV_PD: cover property (mode == MODE_POWERDOWN);
  COV_SB: cover property (mode == MODE_STANDBY);
  COV_OFF: cover property (mode == MODE_SHUTDOWN);
  COV_LO: cover property (lo_to_test);
endmodule : pm_props
bind tuner_power_mode_control pm_props chk_i (.*);
`default_nettype wire

// *** tuner_pm_pkg.sv ***
package tuner_pm_pkg;

  // Register widths
  localparam int DIAG_W = 3;
  localparam int XDIV_W = 5;

  // Diagnostic select codes
  localparam logic [DIAG_W-1:0] DIAG_LO_TO_TEST = 3'h7;
  localparam logic [DIAG_W-1:0] DIAG_DET_VOLT = 3'h4;

  // Power-on defaults
  localparam logic RST_SOFT_SOFT_POWERDOWN_BIT = 1'b0;
  localparam logic RST_STANDBY = 1'b0;
  localparam logic RST_DET_EN = 1'b0;
  localparam logic [DIAG_W-1:0] RST_DIAG = 3'h0;
  localparam logic [XDIV_W-1:0] RST_XDIV = 5'h01;

  // Input synchroniser depth
  localparam int SYNC_STAGES = 3;

  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_SHUTDOWN,
    MODE_POWERDOWN,
    MODE_STANDBY
  } pm_mode_t;

  // Host-visible configuration held across low-power modes
  typedef struct packed {
    logic soft_powerdown_bit;
    logic standby_select_bit;
    logic detector_enable;
    logic [DIAG_W-1:0] diag_sel;
    logic [XDIV_W-1:0] xtal_div;
  } cfg_t;

  // Domain enables handed to the analog side
  typedef struct packed {
    logic signal_path_on;
    logic serial_if_on;
    logic xtal_osc_on;
    logic ref_buf_on;
    logic ref_div_on;
  } dom_en_t;

  typedef struct packed {
    logic [SYNC_STAGES-1:0] off_sync;
    logic off_n_stable;
    cfg_t cfg;
    pm_mode_t mode;
    dom_en_t dom;
    logic lo_to_test;
    logic det_volt_mode;
    logic det_out_en;
  } pm_state_t;

endpackage : tuner_pm_pkg

// *** tuner_power_mode_control.sv ***
`timescale 1ns/1ps
`default_nettype none
module tuner_power_mode_control
  import tuner_pm_pkg::*;
(
  // Clock and power-on reset
  input wire logic clk,
  input wire logic sys_rst,

  // Shutdown pin, from outside the clock domain
  input wire logic hw_off_n_pin,

  // Register write port from the serial interface
  input wire logic cfg_wr,
  input wire cfg_t cfg_wdata,

  // Configuration readback
  output var cfg_t cfg_rdata,

  // Mode and domain enables
  output var pm_mode_t mode,
  output var dom_en_t dom_en,

  // Diagnostics
  output logic lo_to_test,
  output logic det_volt_mode,
  output logic det_out_en,

  // Write handshake, same cycle as the strobe
  output logic wr_accepted
);

  localparam cfg_t CFG_DEFAULT = '{
    soft_powerdown_bit: RST_SOFT_SOFT_POWERDOWN_BIT,
    standby_select_bit: RST_STANDBY,
    detector_enable: RST_DET_EN,
    diag_sel: RST_DIAG,
    xtal_div: RST_XDIV
  };

  // Every domain running, as after power-on
  localparam dom_en_t DOM_ALL_ON = '{
    signal_path_on: 1'b1,
    serial_if_on: 1'b1,
    xtal_osc_on: 1'b1,
    ref_buf_on: 1'b1,
    ref_div_on: 1'b1
  };

  // Whole block state, registered as one word
  pm_state_t s_q;
  pm_state_t s_d;
  logic hw_off;
  logic wr_ok;

  // Pin outranks both soft bits unless detector_enable is set; power-down outranks standby
  function automatic pm_mode_t decode_mode(
    input logic off,
    input cfg_t c
  );
    pm_mode_t m;

    m = MODE_NORMAL;
    if (off)
    begin
      m = MODE_SHUTDOWN;
    end
    else if (c.soft_powerdown_bit)
    begin
      m = MODE_POWERDOWN;
    end
    else if (c.standby_select_bit)
    begin
      m = MODE_STANDBY;
    end

    return m;
  endfunction : decode_mode

  function automatic dom_en_t domains(
    input pm_mode_t m,
    input logic [XDIV_W-1:0] xd
  );
    dom_en_t d;

    d = '0;
    unique case (m)
      MODE_NORMAL:
      begin
        d = DOM_ALL_ON;
      end

      MODE_SHUTDOWN:
      begin
        // Interface off too: the host cannot reach the block
        d.signal_path_on = 1'b0;
        d.serial_if_on = 1'b0;
        d.xtal_osc_on = 1'b0;
        d.ref_buf_on = 1'b0;
        d.ref_div_on = 1'b0;
      end

      MODE_POWERDOWN:
      begin
        d.signal_path_on = 1'b0;
        d.serial_if_on = 1'b1;
        d.xtal_osc_on = 1'b0;
        d.ref_buf_on = 1'b0;
        d.ref_div_on = 1'b0;
      end

      MODE_STANDBY:
      begin
        d.signal_path_on = 1'b0;
        d.serial_if_on = 1'b1;
        d.xtal_osc_on = 1'b1;
        d.ref_buf_on = 1'b1;
        d.ref_div_on = 1'b1;
      end
    endcase

    // A zero divide ratio disables the reference buffer
    if (xd == '0)
    begin
      d.ref_buf_on = 1'b0;
      d.ref_div_on = 1'b0;
    end

    return d;
  endfunction : domains

  // Diagnostic select decode, shared by the test and detector paths
  function automatic logic diag_is(
    input cfg_t c,
    input logic [DIAG_W-1:0] code
  );
    logic hit;

    hit = (c.diag_sel == code);
    return hit;
  endfunction : diag_is

  // Both late stages must agree before the pin level is believed
  assign hw_off = ~s_q.off_n_stable & ~s_q.cfg.detector_enable;
  // Writes need the serial interface up, so power-down still accepts them
  assign wr_ok = cfg_wr & s_q.dom.serial_if_on;

  always_comb
  begin
    s_d = s_q;

    // Three-flop pin synchroniser; late two stages must agree
    s_d.off_sync = {s_q.off_sync[SYNC_STAGES-2:0], hw_off_n_pin};
    if (s_q.off_sync[SYNC_STAGES-1] == s_q.off_sync[SYNC_STAGES-2])
    begin
      s_d.off_n_stable = s_q.off_sync[SYNC_STAGES-1];
    end

    // Only writes change configuration; mode changes never touch it
    if (wr_ok)
    begin
      s_d.cfg = cfg_wdata;
    end

    s_d.mode = decode_mode(hw_off, s_d.cfg);
    s_d.dom = domains(s_d.mode, s_d.cfg.xtal_div);

    // Route only while the signal path runs
    s_d.lo_to_test = diag_is(s_d.cfg, DIAG_LO_TO_TEST)
                     & s_d.dom.signal_path_on;
    s_d.det_volt_mode = diag_is(s_d.cfg, DIAG_DET_VOLT);
    // Detector drives its pin only while the signal path runs
    s_d.det_out_en = s_d.cfg.detector_enable
                     & s_d.dom.signal_path_on;
  end

  // Reset stands for the supply coming up; nothing else loads defaults
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      // Pin assumed high, so no false shutdown after power-on
      s_q.off_sync <= '1;
      s_q.off_n_stable <= 1'b1;
      s_q.cfg <= CFG_DEFAULT;
      s_q.mode <= MODE_NORMAL;
      s_q.dom <= DOM_ALL_ON;
      s_q.lo_to_test <= 1'b0;
      s_q.det_volt_mode <= 1'b0;
      s_q.det_out_en <= 1'b0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Registered outputs straight from state
  assign cfg_rdata = s_q.cfg;
  assign mode = s_q.mode;
  assign dom_en = s_q.dom;
  assign lo_to_test = s_q.lo_to_test;
  assign det_volt_mode = s_q.det_volt_mode;
  assign det_out_en = s_q.det_out_en;

  // Handshake is combinational so the strobe cycle sees it
  assign wr_accepted = wr_ok;

endmodule : tuner_power_mode_control
`default_nettype wire

// *** tuner_power_mode_control_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tuner_power_mode_control_tb_top import tuner_pm_pkg::*;;
  logic clk = 0, sys_rst = 1, hw_off_n_pin = 1;
  logic cfg_wr, lo_to_test, det_volt_mode, det_out_en, wr_accepted;
  cfg_t cfg_wdata, cfg_rdata;
  pm_mode_t mode;
  dom_en_t dom_en;
  int error_cnt = 0, n_tests = 0;
  always #2.5 clk = ~clk;
  host_bfm host (
    .clk(clk),
    .hw_off_n_pin(hw_off_n_pin),
    .cfg_wr(cfg_wr),
    .cfg_wdata(cfg_wdata)
  );
  tuner_power_mode_control DUT (
    .clk(clk),
    .sys_rst(sys_rst),
    .hw_off_n_pin(hw_off_n_pin),
    .cfg_wr(cfg_wr),
    .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata),
    .mode(mode),
    .dom_en(dom_en),
    .lo_to_test(lo_to_test),
    .det_volt_mode(det_volt_mode),
    .det_out_en(det_out_en),
    .wr_accepted(wr_accepted)
  );
  task automatic chk(logic [15:0] s, e, string n);
    n_tests++;
    error_cnt += (s !== e);
    if (s !== e) $display("wrong value %s exp %h seen %h", n, e, s);
  endtask : chk
  task automatic wrap_up(int x);
    error_cnt += x;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up
  // One host write, with its same-cycle handshake judged
  task automatic put(cfg_t v);
    fork
      host.write(v);
      begin
        @(posedge clk);
        @(negedge clk);
        chk(wr_accepted, 1'b1, "acc");
      end
    join
  endtask : put
  task automatic t_reset;
    @(negedge clk);
    chk(cfg_rdata, 11'h001, "rst");
    chk({mode, dom_en}, {MODE_NORMAL, 5'h1F}, "norm");
    $display("reset test done");
  endtask : t_reset
  task automatic t_pd_off;
    put(11'h4E3);
    chk({mode, dom_en}, {MODE_POWERDOWN, 5'h08}, "pd");
    @(posedge clk) hw_off_n_pin <= 0;
    // Host holds this write back while the pin is low
    host.write(11'h000);
    chk({mode, dom_en}, {MODE_SHUTDOWN, 5'h00}, "off");
    @(posedge clk) hw_off_n_pin <= 1;
    repeat (9) @(negedge clk);
    chk({cfg_rdata, mode}, {11'h4E3, MODE_POWERDOWN}, "kept");
    $display("shutdown test done");
  endtask : t_pd_off
  task automatic t_sb_diag;
    put(11'h2E3);
    chk({lo_to_test, dom_en}, {1'b0, 5'h0F}, "sb");
    put(11'h0E3);
    chk({det_volt_mode, lo_to_test, dom_en}, {2'b01, 5'h1F}, "lo");
    put(11'h080);
    chk({det_volt_mode, lo_to_test}, 2'b10, "det");
    $display("diagnostic test done");
  endtask : t_sb_diag
  task automatic t_detector;
    put(11'h103);
    chk({det_out_en, det_volt_mode}, 2'b10, "detctl");
    @(posedge clk) hw_off_n_pin <= 0;
    repeat (9) @(negedge clk);
    chk(mode, MODE_NORMAL, "deten");
    @(posedge clk) hw_off_n_pin <= 1;
    repeat (9) @(negedge clk);
    $display("detector test done");
  endtask : t_detector
  task automatic t_power_on;
    @(posedge clk) sys_rst <= 1;
    repeat (2) @(posedge clk);
    sys_rst <= 0;
    @(negedge clk);
    chk(cfg_rdata, 11'h001, "rst2");
    $display("power-on test done");
  endtask : t_power_on
  initial
  begin
    repeat (2) @(posedge clk);
    sys_rst <= 0;
    t_reset();
    t_pd_off();
    t_sb_diag();
    t_detector();
    t_power_on();
    wrap_up(0);
  end
  initial #5000 wrap_up(1);
endmodule : tuner_power_mode_control_tb_top
`default_nettype wire
